// ---- fre_map.svh ----
// Register offsets, field positions, reset values and address constants
`ifndef FRE_MAP_SVH
`define FRE_MAP_SVH

`define FRE_OFS_EMU        8'h00
`define FRE_OFS_RAMCTL     8'h01
`define FRE_OFS_PROG       8'h02

`define FRE_EMU_OVL_BIT    7
`define FRE_EMU_RHI_BIT    3
`define FRE_EMU_RLO_BIT    2
`define FRE_EMU_RESET      8'h73
`define FRE_EMU_ONES       8'h73

`define FRE_RC_ENA_BIT     7
`define FRE_RC_ENB_BIT     5
`define FRE_RC_FHI_BIT     2
`define FRE_RC_FLO_BIT     1

`define FRE_PC_PROG_BIT    0
`define FRE_PC_ERASE_BIT   1
`define FRE_PC_SWE_BIT     3

`define FRE_MODE_A         3'h2
`define FRE_MODE_B         3'h4
`define FRE_MODE_C         3'h7

`define FRE_FLASH_TOP      4'h0
`define FRE_RAM_TOP        4'hf
`define FRE_RAM_NO_BLOCK   2'h3

`endif

// ---- fre_pkg.sv ----
// Types shared by the overlay emulation block
package fre_pkg;

  typedef struct packed {
    logic [2:0] mode_s1;
    logic [2:0] mode_s2;
    logic       fwe_s1;
    logic       fwe_s2;
    logic       stby_s1;
    logic       stby_s2;
    logic       nmi_s1;
    logic       nmi_s2;
    logic       ovl_en;
    logic       ram_sel_hi;
    logic       ram_sel_lo;
    logic       flash_sel_hi;
    logic       flash_sel_lo;
    logic       ram_en_a;
    logic       ram_en_b;
    logic       prog;
    logic       erase;
    logic       software_write_enable;
    logic [7:0] rdata;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic       mem_ram;
    logic       mem_rd;
    logic       mem_wr;
  } fre_state_t;

endpackage : fre_pkg

// ---- fre_remap.sv ----
// Combinational flash-to-RAM address translation
`timescale 1ns/1ps
`include "fre_map.svh"

module fre_remap (
  input  wire logic [15:0] cpu_addr,
  input  wire logic        ovl_active,
  input  wire logic [1:0]  flash_blk,
  input  wire logic [1:0]  ram_blk,
  output logic      [15:0] phys_addr,
  output logic             to_ram,
  output logic             overlaid
);

  always_comb begin
    phys_addr = cpu_addr;
    overlaid  = 1'b0;
    to_ram    = (cpu_addr[15:12] == `FRE_RAM_TOP) &&
                (cpu_addr[11:10] != `FRE_RAM_NO_BLOCK);
    if (ovl_active && cpu_addr[15:12] == `FRE_FLASH_TOP &&
        cpu_addr[11:10] == flash_blk) begin
      phys_addr = {`FRE_RAM_TOP, ram_blk, cpu_addr[9:0]};
      to_ram    = 1'b1;
      overlaid  = 1'b1;
    end
  end

endmodule : fre_remap

// ---- fre_top.sv ----
// Flash overlay emulation: control registers, remap and program guard
// Operation
// - A RAM block can replace accesses to part of flash 0000-0FFF.
// - Overlay enable plus RAM and flash block selects control remapping.
// - Flash select 00..11 picks window 0000,0400,0800,0C00; protection on.
// - RAM select 00,01,10 picks source F000, F400, F800.
// - RAM select 11 maps exactly like 10 but reads back as 11.
// - Selected RAM stays reachable at its own addresses too.
// - Overlay control bits are writable and effective only in modes 2,4,7.
// - In other modes overlay bits read zero and no overlay occurs.
// - NMI is blocked while program or erase bit is set.
// - Program and erase clear on reset, standby, pin low or enable low.
`timescale 1ns/1ps
`include "fre_map.svh"

module fre_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [2:0]  op_mode,
  input  wire logic        write_enable_pin,
  input  wire logic        standby,
  input  wire logic        nmi_in,
  output logic             nmi_out,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  input  wire logic        cpu_rd,
  input  wire logic        cpu_wr,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             mem_ram_sel,
  output logic             mem_flash_sel,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic             overlay_active,
  output logic             flash_program,
  output logic             flash_erase
);

  fre_pkg::fre_state_t state_reg;
  fre_pkg::fre_state_t state_next;

  logic        mode_ok;
  logic        ovl_act;
  logic [1:0]  flash_blk;
  logic [1:0]  ram_blk;
  logic [15:0] phys_addr;
  logic        to_ram;
  logic        overlaid;
  logic        pe_hold;
  logic [7:0]  emu_view;
  logic [7:0]  ramctl_view;
  logic [7:0]  prog_view;

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic mode_allows(input logic [2:0] m);
    mode_allows = (m == `FRE_MODE_A) || (m == `FRE_MODE_B) ||
                  (m == `FRE_MODE_C);
  endfunction : mode_allows

  // Build a byte with one bit placed at a given position
  function automatic logic [7:0] bit_at(input logic v, input int pos);
    bit_at = 8'h00;
    bit_at[pos] = v;
  endfunction : bit_at

  //////////////////////////////////////////////////////////////////////////
  // Derived control

  assign mode_ok   = mode_allows(state_reg.mode_s2);
  assign ovl_act   = mode_ok && state_reg.ovl_en;
  assign flash_blk = {state_reg.flash_sel_hi, state_reg.flash_sel_lo};
  // Select 11 folds onto 10
  assign ram_blk   = {state_reg.ram_sel_hi,
                      state_reg.ram_sel_lo & ~state_reg.ram_sel_hi};
  // Program and erase may only stay set while the pin is high, not standby
  assign pe_hold   = state_reg.fwe_s2 && !state_reg.stby_s2;

  // Overlay bits read zero outside the permitted modes; fixed bits read one
  assign emu_view = `FRE_EMU_ONES |
                    bit_at(mode_ok & state_reg.ovl_en, `FRE_EMU_OVL_BIT) |
                    bit_at(mode_ok & state_reg.ram_sel_hi,
                           `FRE_EMU_RHI_BIT) |
                    bit_at(mode_ok & state_reg.ram_sel_lo,
                           `FRE_EMU_RLO_BIT);
  assign ramctl_view = bit_at(state_reg.ram_en_a, `FRE_RC_ENA_BIT) |
                       bit_at(state_reg.ram_en_b, `FRE_RC_ENB_BIT) |
                       bit_at(mode_ok & state_reg.flash_sel_hi,
                              `FRE_RC_FHI_BIT) |
                       bit_at(mode_ok & state_reg.flash_sel_lo,
                              `FRE_RC_FLO_BIT);
  assign prog_view = bit_at(state_reg.prog, `FRE_PC_PROG_BIT) |
                     bit_at(state_reg.erase, `FRE_PC_ERASE_BIT) |
                     bit_at(state_reg.software_write_enable, `FRE_PC_SWE_BIT);

  //////////////////////////////////////////////////////////////////////////
  // Address translation

  fre_remap u_remap (
    .cpu_addr   (cpu_addr),
    .ovl_active (ovl_act),
    .flash_blk  (flash_blk),
    .ram_blk    (ram_blk),
    .phys_addr  (phys_addr),
    .to_ram     (to_ram),
    .overlaid   (overlaid)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_next = state_reg;

    // Pin synchronisers
    state_next.mode_s1 = op_mode;
    state_next.mode_s2 = state_reg.mode_s1;
    state_next.fwe_s1  = write_enable_pin;
    state_next.fwe_s2  = state_reg.fwe_s1;
    state_next.stby_s1 = standby;
    state_next.stby_s2 = state_reg.stby_s1;
    state_next.nmi_s1  = nmi_in;
    state_next.nmi_s2  = state_reg.nmi_s1;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `FRE_OFS_EMU: begin
          if (mode_ok) begin
            state_next.ovl_en     = reg_wdata[`FRE_EMU_OVL_BIT];
            state_next.ram_sel_hi = reg_wdata[`FRE_EMU_RHI_BIT];
            state_next.ram_sel_lo = reg_wdata[`FRE_EMU_RLO_BIT];
          end
        end
        `FRE_OFS_RAMCTL: begin
          state_next.ram_en_a = reg_wdata[`FRE_RC_ENA_BIT];
          state_next.ram_en_b = reg_wdata[`FRE_RC_ENB_BIT];
          if (mode_ok) begin
            state_next.flash_sel_hi = reg_wdata[`FRE_RC_FHI_BIT];
            state_next.flash_sel_lo = reg_wdata[`FRE_RC_FLO_BIT];
          end
        end
        `FRE_OFS_PROG: begin
          state_next.software_write_enable   = reg_wdata[`FRE_PC_SWE_BIT];
          state_next.prog  = reg_wdata[`FRE_PC_PROG_BIT];
          state_next.erase = reg_wdata[`FRE_PC_ERASE_BIT];
        end
        default: begin
        end
      endcase
    end

    if (state_reg.stby_s2) begin
      state_next.software_write_enable = 1'b0;
    end
    // Program and erase cannot survive loss of their enables; the enable
    // bit is taken as written, so one write may set it with program
    if (!pe_hold || !state_next.software_write_enable) begin
      state_next.prog  = 1'b0;
      state_next.erase = 1'b0;
    end

    // Register reads: data stands in the following cycle only
    state_next.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `FRE_OFS_EMU:    state_next.rdata = emu_view;
        `FRE_OFS_RAMCTL: state_next.rdata = ramctl_view;
        `FRE_OFS_PROG:   state_next.rdata = prog_view;
        default:         state_next.rdata = 8'h00;
      endcase
    end

    // CPU access steering, one cycle behind the request
    state_next.mem_addr  = phys_addr;
    state_next.mem_wdata = cpu_wdata;
    state_next.mem_ram   = to_ram;
    state_next.mem_rd    = cpu_rd;
    state_next.mem_wr    = cpu_wr;
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg            <= '0;
      state_reg.ram_sel_hi <= 1'(`FRE_EMU_RESET >> `FRE_EMU_RHI_BIT);
      state_reg.ram_sel_lo <= 1'(`FRE_EMU_RESET >> `FRE_EMU_RLO_BIT);
      state_reg.ovl_en     <= 1'(`FRE_EMU_RESET >> `FRE_EMU_OVL_BIT);
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata      = state_reg.rdata;
  assign mem_addr       = state_reg.mem_addr;
  assign mem_wdata      = state_reg.mem_wdata;
  assign mem_ram_sel    = state_reg.mem_ram;
  assign mem_flash_sel  = !state_reg.mem_ram &&
                          state_reg.mem_addr[15:12] != `FRE_RAM_TOP;
  assign mem_rd         = state_reg.mem_rd;
  assign mem_wr         = state_reg.mem_wr;
  assign overlay_active = ovl_act;
  // NMI held back while a program or erase bit is set
  assign nmi_out        = state_reg.nmi_s2 &&
                          !(state_reg.prog || state_reg.erase);
  // Real flash is protected while the overlay is on
  assign flash_program  = state_reg.prog && !ovl_act;
  assign flash_erase    = state_reg.erase && !ovl_act;

endmodule : fre_top

// ---- fre_top_props.sv ----
// Port checker for the flash overlay emulation block
`timescale 1ns/1ps
module fre_top_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [2:0]  op_mode,
  input wire logic        nmi_in,
  input wire logic        nmi_out,
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_rd,
  input wire logic        cpu_wr,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_ram_sel,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic        overlay_active,
  input wire logic        flash_program,
  input wire logic        flash_erase
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////
  ones_rd_a: assert property (!$past(rst) && $past(reg_rd) &&
    $past(reg_addr) == 8'h00 |-> reg_rdata[6:4] == 3'h7 &&
    reg_rdata[1:0] == 2'h3) else $error("unused bits not one");
  mode_ovl_a: assert property (overlay_active |->
    $past(op_mode, 2) inside {3'h2, 3'h4, 3'h7}) else $error("bad mode");
  mode_rd_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00 &&
    !($past(op_mode, 3) inside {3'h2, 3'h4, 3'h7}) |->
    reg_rdata[7] == 1'b0 && reg_rdata[3:2] == 2'h0) else $error("bits read");
  nmi_gate_a: assert property (nmi_out |-> $past(nmi_in, 2) &&
    !flash_program && !flash_erase) else $error("nmi not blocked");
  pe_reset_a: assert property ($past(rst) |->
    !flash_program && !flash_erase) else $error("prog after reset");
  own_ram_a: assert property (!$past(rst) && $past(cpu_addr[15:12]) ==
    4'hf && $past(cpu_addr[11:10]) != 2'h3 |-> mem_ram_sel &&
    mem_addr == $past(cpu_addr)) else $error("own view lost");
  window_a: assert property (!$past(rst) && mem_ram_sel &&
    $past(cpu_addr[15:12]) == 4'h0 |-> mem_addr[15:12] == 4'hf &&
    mem_addr[11:10] != 2'h3 && mem_addr[9:0] == $past(cpu_addr[9:0]))
    else $error("bad window");
  no_ovl_a: assert property (!$past(rst) && !$past(overlay_active) |->
    mem_addr == $past(cpu_addr)) else $error("remap while off");
  strobe_a: assert property (!$past(rst) |-> mem_rd == $past(cpu_rd) &&
    mem_wr == $past(cpu_wr)) else $error("strobe lost");
  cover property (overlay_active && cpu_wr);
  cover property (nmi_in && flash_erase);
  cover property ($fell(flash_erase));
endmodule : fre_top_props
bind fre_top fre_top_props u_props (.*);

// ---- fre_cpu_model.sv ----
// Behavioural CPU issuing bus accesses to the block
`timescale 1ns/1ps
module fre_cpu_model (
  input  wire logic        clk,
  output logic      [15:0] cpu_addr,
  output logic      [7:0]  cpu_wdata,
  output logic             cpu_rd,
  output logic             cpu_wr
);
  initial begin
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // One-cycle access; write data is inverted once no longer qualified
  task automatic access(input logic [15:0] a, input logic w,
                        input logic [7:0] d);
    @(posedge clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_rd <= !w;
    cpu_wr <= w;
    @(posedge clk);
    cpu_rd <= 1'b0;
    cpu_wr <= 1'b0;
    cpu_wdata <= ~d;
  endtask : access
endmodule : fre_cpu_model

// ---- fre_top_test.sv ----
// Self-checking bench for the flash overlay emulation block
`timescale 1ns/1ps
module fre_top_test;
  logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        write_enable_pin = 1'b0, standby = 1'b0, nmi_in = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [7:0]  cpu_wdata, mem_wdata;
  logic [2:0]  op_mode = 3'h0;
  logic [15:0] cpu_addr, mem_addr;
  logic        cpu_rd, cpu_wr, nmi_out, mem_ram_sel, mem_flash_sel;
  logic        mem_rd, mem_wr, overlay_active, flash_program, flash_erase;
  int          err_total = 0;
  int          samples_checked = 0;
  always #4 clk = ~clk;
  fre_top u_dut (.*);
  fre_cpu_model u_cpu (.*);
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [19:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd_reg
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    err_total++;
    final_report();
  end
  initial begin
    logic [7:0] v;
    logic [15:0] x;
    int i, f, r;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'h00, v);
    chk("emu_reset", v, 8'h73);
    @(posedge clk) op_mode <= 3'h1;
    wr_reg(8'h00, 8'hff);
    wr_reg(8'h01, 8'ha6);
    rd_reg(8'h00, v);
    chk("emu_gated", v, 8'h73);
    rd_reg(8'h01, v);
    chk("ramctl_gated", v, 8'ha0);
    rd_reg(8'h33, v);
    chk("unmapped", v, 8'h00);
    for (i = 0; i < 4; i++) begin
      f = i;
      r = 3 - i;
      x = 16'hf015 + 16'((r == 3 ? 2 : r) * 1024);
      @(posedge clk) op_mode <= (i == 1) ? 3'h4 : (i == 2) ? 3'h7 : 3'h2;
      repeat (3) @(posedge clk);
      wr_reg(8'h01, 8'ha0 | 8'(f << 1));
      wr_reg(8'h00, 8'h80 | 8'(r << 2));
      rd_reg(8'h00, v);
      chk("emu_rd", {overlay_active, v}, {1'b1, 8'hf3 | 8'(r << 2)});
      u_cpu.access(16'(f * 1024 + 21), 1'b1, 8'(i));
      #1 chk("mapped", {mem_ram_sel, mem_wr, mem_addr}, {2'h3, x});
      chk("wdata", mem_wdata, 8'(i));
      u_cpu.access(x, 1'b0, 8'h00);
      #1 chk("own_view", {mem_ram_sel, mem_rd, mem_addr}, {2'h3, x});
    end
    @(posedge clk) op_mode <= 3'h1;
    repeat (3) @(posedge clk);
    rd_reg(8'h00, v);
    chk("emu_off", {overlay_active, v}, 9'h073);
    u_cpu.access(16'h0015, 1'b0, 8'h00);
    #1 chk("flash", {mem_flash_sel, mem_ram_sel, mem_addr}, 18'h20015);
    // Programming only once the overlay is turned off
    @(posedge clk) op_mode <= 3'h4;
    write_enable_pin <= 1'b1;
    nmi_in <= 1'b1;
    repeat (3) @(posedge clk);
    wr_reg(8'h02, 8'h09);
    #1 chk("protect", {nmi_out, flash_program}, 2'h0);
    wr_reg(8'h00, 8'h00);
    #1 chk("program", {nmi_out, flash_program}, 2'h1);
    // Erase cleared by pin low, standby, then enable bit low
    for (i = 0; i < 3; i++) begin
      wr_reg(8'h02, 8'h0a);
      #1 chk("erase_set", flash_erase, 1'b1);
      if (i == 2) wr_reg(8'h02, 8'h02);
      @(posedge clk) write_enable_pin <= (i != 0);
      standby <= (i == 1);
      for (f = 0; f < 8 && flash_erase !== 1'b0; f++) @(negedge clk);
      chk("erase_clear", {flash_erase, nmi_out}, 2'h1);
      @(posedge clk) standby <= 1'b0;
      write_enable_pin <= 1'b1;
      repeat (3) @(posedge clk);
    end
    final_report();
  end
endmodule : fre_top_test
